// File: rtl/hwc_pkg.sv
package hwc_pkg;

	// ==========================================================
	// bus map, byte addresses
	localparam int         ADDR_W      = 9;
	localparam logic [8:0] OFS_CTRL    = 9'h000;
	localparam logic [8:0] OFS_RTC     = 9'h004;
	localparam logic [8:0] OFS_MATCH0  = 9'h008;
	localparam logic [8:0] OFS_MATCH1  = 9'h00c;
	localparam logic [8:0] OFS_TRIM    = 9'h010;
	localparam logic [8:0] OFS_IRQ_EN  = 9'h014;
	localparam logic [8:0] OFS_IRQ_RAW = 9'h018;
	localparam logic [8:0] OFS_IRQ_MSK = 9'h01c;
	localparam logic [8:0] OFS_IRQ_CLR = 9'h020;
	localparam logic [8:0] OFS_STATUS  = 9'h024;
	localparam logic [8:0] OFS_STORE   = 9'h100;
	localparam int         STORE_WORDS = 64;
	localparam int         STORE_AW    = 6;

	// ==========================================================
	// reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] RTC_RST   = 32'h0000_0000;
	localparam logic [31:0] MATCH_RST = 32'hffff_ffff;
	localparam logic [15:0] TRIM_RST  = 16'h7fff;
	localparam logic [3:0]  IRQ_RST   = 4'h0;

	// ==========================================================
	// interrupt bit positions
	localparam int IRQ_PIN_WAKE   = 0;
	localparam int IRQ_LOW_BAT    = 1;
	localparam int IRQ_MATCH0     = 2;
	localparam int IRQ_MATCH1     = 3;
	localparam int IRQ_N          = 4;

	// ==========================================================
	// timing
	localparam int         MCLK_PERIOD_NS = 5;
	localparam int         XTAL_DIV       = 128;
	localparam int         HIB_LAG_NS     = 100;
	localparam int         HIB_LAG_CYC    = (HIB_LAG_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam logic [6:0] XTAL_DIV_LAST  = 7'(XTAL_DIV - 1);
	localparam logic [7:0] HIB_LAG_LAST   = 8'(HIB_LAG_CYC - 1);

	// ==========================================================
	// types
	typedef struct packed {
		logic [23:0] rsv;
		logic        wake_rtc;
		logic        wake_pin;
		logic        lowbat_abort;
		logic        lowbat_detect;
		logic        hib_request;
		logic        clock_select_crystal_divided;
		logic        rtc_enable;
		logic        enable;
	} hwc_ctrl_t;

	typedef struct packed {
		logic match1;
		logic match0;
		logic irq_battery_low;
		logic pin_wake;
	} hwc_irq_t;

	typedef enum logic [1:0] {
		HWC_RUN,
		HWC_LAG,
		HWC_OFF
	} hwc_pwr_t;

endpackage : hwc_pkg

// File: rtl/hwc_store.sv
`timescale 1ns/100ps
module hwc_store
	import hwc_pkg::*;
(
	input  wire logic                mclk_i,
	input  wire logic                we_i,
	input  wire logic [STORE_AW-1:0] addr_i,
	input  wire logic [31:0]         wdata_i,
	input  wire logic [3:0]          be_i,
	output logic      [31:0]         rdata_o
);

	// ==========================================================
	// storage: no reset, so contents outlive processor power-down
	// one array per byte lane, so each lane has a single writer
	genvar b;
	generate
		for (b = 0; b < 4; b++)
		begin : g_lane
			logic [7:0] mem [STORE_WORDS];

			always_ff @(posedge mclk_i)
			begin
				if (we_i && be_i[b])
					mem[addr_i] <= wdata_i[8*b +: 8];
				rdata_o[8*b +: 8] <= mem[addr_i];
			end
		end
	endgenerate

endmodule : hwc_store

// File: rtl/hwc_top.sv
// Function
// - nothing operates until the module enable bit is set.
// - time base is raw 32.768 kHz oscillator or crystal divided by 128.
// - counter enable starts or stops counting at any moment.
// - counter is readable and loadable by software.
// - two readable, writable match registers compared with the counter.
// - readable, writable trim sets the counter rate.
// - 64 words of retained 32-bit storage.
// - wake on pin, clock match or both; configuration reads back.
// - low battery flagged; optional abort of hibernation request.
// - four interrupt sources each enabled by its mask bit.
// - pending flags read and cleared per bit; uncleared stays asserted.
// - hibernation request starts power removal after a lag.
// - enable state survives hibernation and reads back.
// - raw flags keep the wake cause across the power cycle.
// - disabling stops counting, matching, waking, battery detect, interrupts.
// - match event when counter equals match register.
// - regulator off on hibernation, back on at wake.
`timescale 1ns/100ps
module hwc_top
	import hwc_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              reset_i,
	input  wire logic [ADDR_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	input  wire logic              osc_32k_i,
	input  wire logic              xtal_i,
	input  wire logic              wake_n_i,
	input  wire logic              low_battery_i,
	output logic                   regulator_en_o,
	output logic                   irq_o
);

	// ==========================================================
	// pin synchronisers
	localparam int NPIN = 4;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync1_ff;
	logic [NPIN-1:0] sync2_ff;
	logic [NPIN-1:0] sync3_ff;

	assign pin_raw = {low_battery_i, ~wake_n_i, xtal_i, osc_32k_i};

	genvar p;
	generate
		for (p = 0; p < NPIN; p++)
		begin : g_sync
			always_ff @(posedge mclk_i)
			begin
				if (reset_i)
				begin
					sync1_ff[p] <= 1'b0;
					sync2_ff[p] <= 1'b0;
					sync3_ff[p] <= 1'b0;
				end
				else
				begin
					sync1_ff[p] <= pin_raw[p];
					sync2_ff[p] <= sync1_ff[p];
					sync3_ff[p] <= sync2_ff[p];
				end
			end
		end
	endgenerate

	logic osc_rise;
	logic xtal_rise;
	logic wake_rise;
	logic low_bat;
	assign osc_rise  = sync2_ff[0] & ~sync3_ff[0];
	assign xtal_rise = sync2_ff[1] & ~sync3_ff[1];
	assign wake_rise = sync2_ff[2] & ~sync3_ff[2];
	assign low_bat   = sync2_ff[3];

	// ==========================================================
	// register state
	hwc_ctrl_t   ctrl_ff;
	logic [31:0] rtc_ff;
	logic [31:0] match0_ff;
	logic [31:0] match1_ff;
	logic [15:0] trim_ff;
	logic [15:0] sub_ff;
	logic [6:0]  div_ff;
	logic [3:0]  irq_en_ff;
	logic [3:0]  raw_ff;
	hwc_pwr_t    pwr_ff;
	logic [7:0]  lag_ff;

	logic en;
	logic wr;
	assign en = ctrl_ff.enable;
	assign wr = avs_write_i;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : merge

	logic ctrl_wr;
	logic rtc_wr;
	logic hib_req;
	assign ctrl_wr = wr && avs_address_i == OFS_CTRL;
	assign rtc_wr  = wr && avs_address_i == OFS_RTC;
	assign hib_req = ctrl_wr && avs_byteenable_i[0] && avs_writedata_i[3];

	// ==========================================================
	// control; request bit is a pulse and is never stored
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			ctrl_ff <= CTRL_RST;
		else if (ctrl_wr)
		begin
			ctrl_ff             <= merge(ctrl_ff, avs_writedata_i, avs_byteenable_i);
			ctrl_ff.hib_request <= 1'b0;
			ctrl_ff.rsv         <= '0;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			match0_ff <= MATCH_RST;
			match1_ff <= MATCH_RST;
			trim_ff   <= TRIM_RST;
			irq_en_ff <= IRQ_RST;
		end
		else if (wr)
		begin
			if (avs_address_i == OFS_MATCH0)
				match0_ff <= merge(match0_ff, avs_writedata_i, avs_byteenable_i);
			if (avs_address_i == OFS_MATCH1)
				match1_ff <= merge(match1_ff, avs_writedata_i, avs_byteenable_i);
			if (avs_address_i == OFS_TRIM)
				trim_ff <= 16'(merge({16'h0, trim_ff}, avs_writedata_i, avs_byteenable_i));
			if (avs_address_i == OFS_IRQ_EN)
				irq_en_ff <= avs_byteenable_i[0] ? avs_writedata_i[3:0] : irq_en_ff;
		end
	end

	// ==========================================================
	// time base
	logic slow_tick;
	logic sec_tick;

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			div_ff <= 7'h00;
		else if (xtal_rise)
			div_ff <= (div_ff == XTAL_DIV_LAST) ? 7'h00 : div_ff + 7'h01;
	end

	assign slow_tick = ctrl_ff.clock_select_crystal_divided ? (xtal_rise && div_ff == XTAL_DIV_LAST) : osc_rise;
	assign sec_tick  = en && ctrl_ff.rtc_enable && slow_tick && sub_ff >= trim_ff;

	// trim sets the ticks per second
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			sub_ff <= 16'h0000;
		else if (!(en && ctrl_ff.rtc_enable))
			sub_ff <= 16'h0000;
		else if (slow_tick)
			sub_ff <= sec_tick ? 16'h0000 : sub_ff + 16'h0001;
	end

	// counter runs only while its enable is set
	// software load wins over the tick
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			rtc_ff <= RTC_RST;
		else if (rtc_wr)
			rtc_ff <= merge(rtc_ff, avs_writedata_i, avs_byteenable_i);
		else if (sec_tick)
			rtc_ff <= rtc_ff + 32'h1;
	end

	// ==========================================================
	// events and flags
	logic [3:0] ev_set;
	logic [3:0] ev_clr;
	logic       hit0;
	logic       hit1;

	// compare the value the counter is about to take
	assign hit0 = sec_tick && !rtc_wr && (rtc_ff + 32'h1) == match0_ff;
	assign hit1 = sec_tick && !rtc_wr && (rtc_ff + 32'h1) == match1_ff;

	// battery flag only while detection is on
	assign ev_set[IRQ_PIN_WAKE] = en && wake_rise;
	assign ev_set[IRQ_LOW_BAT]  = en && ctrl_ff.lowbat_detect && low_bat;
	assign ev_set[IRQ_MATCH0]   = hit0;
	assign ev_set[IRQ_MATCH1]   = hit1;
	assign ev_clr = (wr && avs_address_i == OFS_IRQ_CLR && avs_byteenable_i[0]) ? avs_writedata_i[3:0] : 4'h0;

	genvar q;
	generate
		for (q = 0; q < IRQ_N; q++)
		begin : g_flag
			always_ff @(posedge mclk_i)
			begin
				if (reset_i)
					raw_ff[q] <= 1'b0;
				else
					raw_ff[q] <= ev_set[q] | (raw_ff[q] & ~ev_clr[q]);
			end
		end
	endgenerate

	assign irq_o = en && |(raw_ff & irq_en_ff);

	// ==========================================================
	// power sequencer
	logic req_ok;
	logic wake;
	assign req_ok = en && hib_req && !(ctrl_ff.lowbat_abort && low_bat);
	assign wake = en && ((ctrl_ff.wake_pin && wake_rise) || (ctrl_ff.wake_rtc && (hit0 || hit1)));

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			pwr_ff <= HWC_RUN;
			lag_ff <= 8'h00;
		end
		else
		begin
			unique case (pwr_ff)
				HWC_RUN:
				begin
					lag_ff <= 8'h00;
					if (req_ok)
						pwr_ff <= HWC_LAG;
				end
				HWC_LAG:
				begin
					lag_ff <= lag_ff + 8'h01;
					if (!en)
						pwr_ff <= HWC_RUN;
					else if (lag_ff == HIB_LAG_LAST)
						pwr_ff <= HWC_OFF;
				end
				HWC_OFF:
				begin
					if (wake || !en)
						pwr_ff <= HWC_RUN;
				end
			endcase
		end
	end

	assign regulator_en_o = pwr_ff != HWC_OFF;

	// ==========================================================
	// retained store
	logic [31:0] store_q;
	logic        store_sel;
	assign store_sel = avs_address_i >= OFS_STORE;

	hwc_store u_store (
		.mclk_i  (mclk_i),
		.we_i    (wr && store_sel),
		.addr_i  (avs_address_i[STORE_AW+1:2]),
		.wdata_i (avs_writedata_i),
		.be_i    (avs_byteenable_i),
		.rdata_o (store_q)
	);

	// ==========================================================
	// read path: one wait cycle on every read
	logic        rd_ack_ff;
	logic        sel_store_ff;
	logic [31:0] rd_ff;
	logic [31:0] nxt_rd;

	always_comb
	begin
		nxt_rd = 32'h0;
		unique case (avs_address_i)
			OFS_CTRL:    nxt_rd = ctrl_ff;
			OFS_RTC:     nxt_rd = rtc_ff;
			OFS_MATCH0:  nxt_rd = match0_ff;
			OFS_MATCH1:  nxt_rd = match1_ff;
			OFS_TRIM:    nxt_rd = {16'h0, trim_ff};
			OFS_IRQ_EN:  nxt_rd = {28'h0, irq_en_ff};
			OFS_IRQ_RAW: nxt_rd = {28'h0, raw_ff};
			OFS_IRQ_MSK: nxt_rd = {28'h0, raw_ff & irq_en_ff};
			OFS_STATUS:  nxt_rd = {28'h0, regulator_en_o, pwr_ff == HWC_LAG, low_bat, en};
			default:     nxt_rd = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			rd_ack_ff    <= 1'b0;
			sel_store_ff <= 1'b0;
			rd_ff        <= 32'h0;
		end
		else
		begin
			rd_ack_ff    <= avs_read_i && !rd_ack_ff;
			sel_store_ff <= store_sel;
			rd_ff        <= nxt_rd;
		end
	end

	assign avs_waitrequest_o = avs_read_i && !rd_ack_ff;
	assign avs_readdata_o    = sel_store_ff ? store_q : rd_ff;

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	property p_disable_freeze;
		!en && !rtc_wr |=> rtc_ff == $past(rtc_ff);
	endproperty
	a_disable_freeze: assert property (p_disable_freeze) else $error("counter moved while disabled");

	property p_tick_step;
		sec_tick && !rtc_wr |=> rtc_ff == $past(rtc_ff) + 32'h1;
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("counter did not step on tick");

	property p_load;
		rtc_wr && avs_byteenable_i == 4'hf |=> rtc_ff == $past(avs_writedata_i);
	endproperty
	a_load: assert property (p_load) else $error("counter load lost");

	property p_match0;
		hit0 |=> raw_ff[IRQ_MATCH0] && rtc_ff == match0_ff;
	endproperty
	a_match0: assert property (p_match0) else $error("match 0 not flagged");

	property p_sticky;
		raw_ff[IRQ_LOW_BAT] && !ev_clr[IRQ_LOW_BAT] |=> raw_ff[IRQ_LOW_BAT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

	property p_set_wins;
		ev_set[IRQ_LOW_BAT] && ev_clr[IRQ_LOW_BAT] |=> raw_ff[IRQ_LOW_BAT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

	property p_mask;
		irq_en_ff == 4'h0 |-> !irq_o;
	endproperty
	a_mask: assert property (p_mask) else $error("masked interrupt seen");

	property p_abort;
		en && hib_req && ctrl_ff.lowbat_abort && low_bat && pwr_ff == HWC_RUN |=> pwr_ff == HWC_RUN;
	endproperty
	a_abort: assert property (p_abort) else $error("request not abandoned on low battery");

	property p_power_off;
		req_ok && pwr_ff == HWC_RUN ##1 en[*8] |-> regulator_en_o;
	endproperty
	a_power_off: assert property (p_power_off) else $error("power dropped before the lag");

	property p_power_off_end;
		pwr_ff == HWC_LAG && lag_ff == HIB_LAG_LAST && en |=> !regulator_en_o;
	endproperty
	a_power_off_end: assert property (p_power_off_end) else $error("regulator still on after lag");

	property p_wake;
		pwr_ff == HWC_OFF && wake |=> regulator_en_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no power after wake");

	c_sleep_wake: cover property (pwr_ff == HWC_OFF ##[1:1000] regulator_en_o);
	c_match1:     cover property (hit1 ##1 irq_o);
	c_abort:      cover property (en && hib_req && ctrl_ff.lowbat_abort && low_bat);
	c_store_rd:   cover property (avs_read_i && store_sel ##1 !avs_waitrequest_o);

endmodule : hwc_top

// File: verif/hwc_pwr_model.sv
`timescale 1ns/100ps
module hwc_pwr_model
	import hwc_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic regulator_en_i,
	input  wire logic wake_pulse_i,
	input  wire logic batt_low_i,
	output logic      wake_n_o,
	output logic      low_battery_o,
	output logic      osc_32k_o,
	output logic      xtal_o,
	output logic      core_on_o
);
	// ==========================================================
	// slow sources, free running like the real parts
	logic [2:0] div_ff;
	logic [3:0] wake_ff;
	initial div_ff = 3'h0;
	initial wake_ff = 4'h0;
	always @(posedge mclk_i)
	begin
		div_ff <= div_ff + 3'h1;
	end
	// osc period 8 cycles, crystal period 4 cycles
	assign osc_32k_o = div_ff[2];
	assign xtal_o = div_ff[1];

	// ==========================================================
	// wake pin: low for 8 cycles, pull-up otherwise
	always @(posedge mclk_i)
	begin
		if (wake_pulse_i)
			wake_ff <= 4'h8;
		else if (wake_ff != 4'h0)
			wake_ff <= wake_ff - 4'h1;
	end
	assign wake_n_o = (wake_ff == 4'h0);
	assign low_battery_o = batt_low_i;
	assign core_on_o = regulator_en_i;
endmodule : hwc_pwr_model

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import hwc_pkg::*;
;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [8:0]  addr = 9'h0;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'hf;
	logic [31:0] rdata;
	logic        waitreq;
	logic        osc, xtal, wake_n, lowbat, reg_en, irq, core_on;
	logic        wake_pulse = 1'b0;
	logic        batt_low = 1'b0;
	logic [31:0] rv;
	int          num_errors = 0;
	int          checked = 0;

	always #2.5 mclk_i = ~mclk_i;

	hwc_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd_en),
		.avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .osc_32k_i(osc), .xtal_i(xtal),
		.wake_n_i(wake_n), .low_battery_i(lowbat), .regulator_en_o(reg_en), .irq_o(irq));

	hwc_pwr_model pwr (.mclk_i(mclk_i), .regulator_en_i(reg_en), .wake_pulse_i(wake_pulse),
		.batt_low_i(batt_low), .wake_n_o(wake_n), .low_battery_o(lowbat), .osc_32k_o(osc),
		.xtal_o(xtal), .core_on_o(core_on));

	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : cyc

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		do
			@(posedge mclk_i);
		while (waitreq !== 1'b0);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [8:0] a);
		@(posedge mclk_i);
		addr <= a;
		rd_en <= 1'b1;
		do
			@(posedge mclk_i);
		while (waitreq !== 1'b0);
		rv = rdata;
		rd_en <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
		rd(a);
		chk(rv, exp);
	endtask : rdc

	task automatic rng(input logic [31:0] lo, input logic [31:0] hi);
		chk({31'h0, (rv >= lo) && (rv <= hi)}, 32'h1);
	endtask : rng

	// power back within lim cycles
	task automatic wait_pwr(input int lim);
		for (int n = 0; n < lim && core_on !== 1'b1; n++)
			@(posedge mclk_i);
		chk({31'h0, reg_en}, 32'h1);
	endtask : wait_pwr

	// ==========================================================
	// scenarios
	task automatic t_reset;
		rdc(OFS_CTRL, CTRL_RST);
		rdc(OFS_RTC, RTC_RST);
		rdc(OFS_MATCH0, MATCH_RST);
		rdc(OFS_MATCH1, MATCH_RST);
		rdc(OFS_TRIM, {16'h0, TRIM_RST});
		chk({31'h0, reg_en}, 32'h1);
		wr(9'h030, 32'hffff_ffff);
		rdc(9'h030, 32'h0);
		wr(OFS_IRQ_RAW, 32'hf);
		rdc(OFS_IRQ_RAW, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_off;
		wr(OFS_RTC, 32'h5);
		// rtc on, hibernate, both wakes, detect, but module off
		wr(OFS_CTRL, 32'h0000_00da);
		batt_low <= 1'b1;
		cyc(40);
		chk({31'h0, reg_en}, 32'h1);
		rdc(OFS_RTC, 32'h5);
		rdc(OFS_IRQ_RAW, 32'h0);
		batt_low <= 1'b0;
		$display("test disabled done");
	endtask : t_off

	task automatic t_rtc;
		wr(OFS_CTRL, 32'h1);
		cyc(4);
		wr(OFS_TRIM, 32'h3);
		rdc(OFS_TRIM, 32'h3);
		wr(OFS_MATCH1, 32'h1234_5678);
		rdc(OFS_MATCH1, 32'h1234_5678);
		be <= 4'h2;
		wr(OFS_MATCH1, 32'h0000_ab00);
		be <= 4'hf;
		rdc(OFS_MATCH1, 32'h1234_ab78);
		wr(OFS_RTC, 32'h100);
		wr(OFS_CTRL, 32'h3);
		// 4 ticks of 8 cycles make one second
		cyc(320);
		rd(OFS_RTC);
		rng(32'h109, 32'h10b);
		wr(OFS_CTRL, 32'h1);
		rd(OFS_RTC);
		cyc(100);
		rdc(OFS_RTC, rv);
		$display("test rtc done");
	endtask : t_rtc

	task automatic t_match;
		wr(OFS_RTC, 32'h20);
		wr(OFS_MATCH0, 32'h22);
		wr(OFS_IRQ_EN, 32'h4);
		wr(OFS_CTRL, 32'h3);
		cyc(110);
		rdc(OFS_IRQ_RAW, 32'h4);
		rdc(OFS_IRQ_MSK, 32'h4);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_EN, 32'h8);
		cyc(1);
		chk({31'h0, irq}, 32'h0);
		rdc(OFS_IRQ_RAW, 32'h4);
		wr(OFS_IRQ_CLR, 32'h4);
		rdc(OFS_IRQ_RAW, 32'h0);
		$display("test match done");
	endtask : t_match

	task automatic t_lowbat;
		wr(OFS_CTRL, 32'h31);
		batt_low <= 1'b1;
		cyc(8);
		rdc(OFS_IRQ_RAW, 32'h2);
		wr(OFS_CTRL, 32'h39);
		cyc(30);
		chk({31'h0, reg_en}, 32'h1);
		rdc(OFS_STATUS, 32'hb);
		// clear while the battery is still low: the new event wins
		wr(OFS_IRQ_CLR, 32'h2);
		rdc(OFS_IRQ_RAW, 32'h2);
		batt_low <= 1'b0;
		cyc(8);
		wr(OFS_IRQ_CLR, 32'h2);
		rdc(OFS_IRQ_RAW, 32'h0);
		$display("test battery done");
	endtask : t_lowbat

	task automatic t_hib_pin;
		wr(OFS_STORE, 32'hdead_beef);
		wr(9'h1fc, 32'h0123_4567);
		wr(OFS_CTRL, 32'h41);
		rdc(OFS_CTRL, 32'h41);
		wr(OFS_IRQ_EN, 32'h1);
		wr(OFS_CTRL, 32'h49);
		cyc(10);
		chk({31'h0, reg_en}, 32'h1);
		cyc(15);
		chk({31'h0, reg_en}, 32'h0);
		cyc(20);
		chk({31'h0, reg_en}, 32'h0);
		wake_pulse <= 1'b1;
		cyc(1);
		wake_pulse <= 1'b0;
		wait_pwr(40);
		rdc(OFS_CTRL, 32'h41);
		rdc(OFS_IRQ_RAW, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rdc(OFS_STORE, 32'hdead_beef);
		rdc(9'h1fc, 32'h0123_4567);
		wr(OFS_IRQ_CLR, 32'h1);
		$display("test pin wake done");
	endtask : t_hib_pin

	task automatic t_hib_rtc;
		wr(OFS_RTC, 32'h40);
		wr(OFS_MATCH1, 32'h43);
		wr(OFS_CTRL, 32'h8b);
		cyc(25);
		chk({31'h0, reg_en}, 32'h0);
		wait_pwr(200);
		rdc(OFS_IRQ_RAW, 32'h8);
		wr(OFS_IRQ_CLR, 32'h8);
		$display("test rtc wake done");
	endtask : t_hib_rtc

	task automatic t_xtal;
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CTRL, 32'h5);
		cyc(600);
		wr(OFS_TRIM, 32'h0);
		wr(OFS_RTC, 32'h0);
		wr(OFS_CTRL, 32'h7);
		// 512 cycles per tick; the raw source would give about 137
		cyc(1100);
		rd(OFS_RTC);
		rng(32'h1, 32'h3);
		$display("test crystal done");
	endtask : t_xtal

	// ==========================================================
	// run control
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	initial
	begin
		#100000;
		num_errors++;
		end_sim();
	end

	initial
	begin
		repeat (16) @(posedge mclk_i);
		reset_i <= 1'b0;
		t_reset();
		t_off();
		t_rtc();
		t_match();
		t_lowbat();
		t_hib_pin();
		t_hib_rtc();
		t_xtal();
		end_sim();
	end
endmodule : tb_top
